// ===== rtl/swc_defs.vh
// constants for the sweep and output command controller
`ifndef SWC_DEFS_VH
`define SWC_DEFS_VH
// register offsets (word index on the plain register port)
`define SWC_OFF_CMD 4'h0
`define SWC_OFF_ARG_LO 4'h1
`define SWC_OFF_ARG_HI 4'h2
`define SWC_OFF_STATE 4'h3
`define SWC_OFF_START 4'h4
`define SWC_OFF_STOP 4'h5
`define SWC_OFF_TIME 4'h6
`define SWC_OFF_FREQ 4'h7
`define SWC_OFF_CFG 4'h8
`define SWC_OFF_STATUS 4'h9
`define SWC_OFF_STORE 4'hA
// command codes written to the command register
`define SWC_CMD_ROUTE 8'h01
`define SWC_CMD_LOCKOUT 8'h02
`define SWC_CMD_PRESET 8'h03
`define SWC_CMD_REARM 8'h04
`define SWC_CMD_CONT 8'h05
`define SWC_CMD_SHAPE 8'h06
`define SWC_CMD_END_FREQ 8'h07
`define SWC_CMD_STORE 8'h08
`define SWC_CMD_BEGIN_FREQ 8'h09
`define SWC_CMD_DURATION 8'h0A
`define SWC_CMD_DUR_QUERY 8'h0B
`define SWC_CMD_FREQ_SET 8'h0C
`define SWC_CMD_SINGLE 8'h0D
`define SWC_CMD_TRIGGER 8'h0E
`define SWC_CMD_XFER_MODE 8'h0F
`define SWC_CMD_ENHANCE 8'h10
// reset values: frequencies in Hz, sweep time in ms
`define SWC_RST_FREQ 32'h000003E8
`define SWC_RST_START 32'h000F4240
`define SWC_RST_STOP 32'h00989680
`define SWC_RST_TIME 32'h000003E8
`define SWC_MAX_FREQ 32'h01406F3F
`define SWC_MAX_TIME 32'h000F4240
`define SWC_RST_ROUTE 2'h1
`define SWC_RST_SHAPE 2'h1
// status byte: preset clears bits 0,1,2,3,5 and 6
`define SWC_STB_ERR 0
`define SWC_STB_STOP 1
`define SWC_STB_START 2
`define SWC_STB_SWEEP 5
`define SWC_STB_PRESET_KEEP 8'hB0
// one ms tick at 100 MHz
`define SWC_MS_CYCLES 17'h186A0
`endif

// ===== rtl/swc_sweep_ctrl.v
// sweep and output command controller
//
// Overview of operation
// - route command: 1 selects front connector, 2 rear; preset is front.
// - serial lockout command enters remote with local lockout.
// - preset returns table settings to reset values; frequency 1000 Hz.
// - preset leaves the data transfer mode untouched.
// - preset clears status bits 0, 1, 2, 3 and 6; the controller also clears bit 5, the sweep bit.
// - preset keeps stores, mask, enhance mode and other listed items.
// - rearm command enters sweep-reset at start frequency.
// - continuous command starts repeating sweeps, or stops a running one.
// - a frequency set while sweeping stops the sweep.
// - shape command: 1 linear, 2 log, 3 discrete; preset linear.
// - stop frequency up to about 21 MHz; preset 10 MHz.
// - start frequency preset 1 MHz.
// - store copies the current setup into location 0 to 9.
// - single sweep from idle enters sweep-reset at start, no sweep.
// - single sweep in sweep-reset runs exactly one sweep.
// - single sweep while sweeping stops the sweep.
// - sweep time preset 1.0 s.
// - duration query and empty duration set report the sweep time.
// - sweep time accepted from zero up to 1000 s.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "swc_defs.vh"

module swc_sweep_ctrl #(
	parameter MS_CYCLES = `SWC_MS_CYCLES,
	parameter STEP_HZ = 32'h00000064,
	parameter LOCS = 10
) (
	// clock and reset
	input wire clk_sys,
	input wire rst,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// sweep and output hardware
	output reg [31:0] out_freq,
	output reg rear_sel,
	output reg [1:0] sweep_shape,
	output reg sweep_active,
	output reg remote_locked,
	output reg [7:0] status_byte,
	output reg time_report
);

	// one-hot sweep states
	localparam ST_IDLE = 3'b001;
	localparam ST_RESET = 3'b010;
	localparam ST_SWEEP = 3'b100;

	// sweep state and argument latch
	reg [2:0] state_reg;
	reg cont_reg;
	reg [31:0] arg_reg;
	reg arg_empty_reg;
	// sweep settings
	reg [31:0] start_reg;
	reg [31:0] stop_reg;
	reg [31:0] time_reg;
	// output selection and host modes
	reg [1:0] route_reg;
	reg [1:0] shape_reg;
	reg [1:0] xfer_mode_reg;
	reg enhance_reg;
	// ms divider and store readback pointer
	reg [16:0] tick_cnt_reg;
	reg [3:0] store_ptr_reg;
	// ten stored setups: route, shape, start, stop, time
	reg [99:0] store_mem [0:LOCS-1];

	// command decode and sweep stepping
	wire cmd_wr;
	wire [7:0] cmd;
	wire ms_tick;
	wire [31:0] next_freq;
	wire at_end;

	assign cmd_wr = reg_wr && (reg_addr == `SWC_OFF_CMD);
	assign cmd = reg_wdata[7:0];
	assign ms_tick = (tick_cnt_reg == MS_CYCLES[16:0] - 17'h00001);
	// step once per ms; clamp so a coarse step never overshoots stop
	assign next_freq = (out_freq + STEP_HZ >= stop_reg) ? stop_reg :
		out_freq + STEP_HZ;
	// also catches a stop lowered below the output mid-sweep
	assign at_end = (out_freq >= stop_reg);

	// millisecond enable divider, runs only while sweeping
	always @(posedge clk_sys) begin
		if (rst || !sweep_active || ms_tick) begin
			tick_cnt_reg <= 17'h00000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 17'h00001;
		end
	end

	// command interpreter and sweep state machine
	always @(posedge clk_sys) begin
		time_report <= 1'b0;
		if (rst) begin
			// controller state and argument latch
			state_reg <= ST_IDLE;
			cont_reg <= 1'b0;
			arg_reg <= 32'h00000000;
			arg_empty_reg <= 1'b1;
			// sweep settings at their preset values
			start_reg <= `SWC_RST_START;
			stop_reg <= `SWC_RST_STOP;
			time_reg <= `SWC_RST_TIME;
			route_reg <= `SWC_RST_ROUTE;
			shape_reg <= `SWC_RST_SHAPE;
			// host modes; only a power-on reset touches these
			xfer_mode_reg <= 2'h0;
			enhance_reg <= 1'b0;
			store_ptr_reg <= 4'h0;
			// output pins
			out_freq <= `SWC_RST_FREQ;
			rear_sel <= 1'b0;
			sweep_shape <= `SWC_RST_SHAPE;
			sweep_active <= 1'b0;
			remote_locked <= 1'b0;
			status_byte <= 8'h00;
		end else begin
			// status read clears event bits first, so a later set wins
			if (reg_rd && reg_addr == `SWC_OFF_STATUS && !cmd_wr) begin
				status_byte[`SWC_STB_ERR] <= 1'b0;
				status_byte[`SWC_STB_STOP] <= 1'b0;
				status_byte[`SWC_STB_START] <= 1'b0;
			end
			// argument register; a write marks it as supplied
			if (reg_wr && reg_addr == `SWC_OFF_ARG_LO) begin
				arg_reg <= reg_wdata;
				arg_empty_reg <= 1'b0;
			end
			// sweep progress on the ms enable
			if (state_reg == ST_SWEEP && ms_tick) begin
				// stop reached on this tick
				if (at_end) begin
					status_byte[`SWC_STB_STOP] <= 1'b1;
					// continuous sweeps restart; single ones end
					if (cont_reg) begin
						out_freq <= start_reg;
					end else begin
						state_reg <= ST_IDLE;
						sweep_active <= 1'b0;
						status_byte[`SWC_STB_SWEEP] <= 1'b0;
					end
				end else begin
					out_freq <= next_freq;
				end
			end
			// one command per strobe; the argument is used up
			if (cmd_wr) begin
				arg_empty_reg <= 1'b1;
				case (cmd)
				// connector select
				`SWC_CMD_ROUTE: begin
					if (arg_reg == 32'h1 || arg_reg == 32'h2) begin
						route_reg <= arg_reg[1:0];
						rear_sel <= arg_reg[1];
					end else begin
						// any other digit is refused
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// lockout sticks until power-on reset
				`SWC_CMD_LOCKOUT: begin
					remote_locked <= 1'b1;
				end
				// preset: table settings only
				`SWC_CMD_PRESET: begin
					// xfer mode, enhance, stores kept
					state_reg <= ST_IDLE;
					cont_reg <= 1'b0;
					// sweep settings back to preset
					start_reg <= `SWC_RST_START;
					stop_reg <= `SWC_RST_STOP;
					time_reg <= `SWC_RST_TIME;
					// outputs back to preset
					out_freq <= `SWC_RST_FREQ;
					route_reg <= `SWC_RST_ROUTE;
					rear_sel <= 1'b0;
					shape_reg <= `SWC_RST_SHAPE;
					sweep_shape <= `SWC_RST_SHAPE;
					sweep_active <= 1'b0;
					status_byte <= status_byte & `SWC_STB_PRESET_KEEP
						& 8'hDF;
				end
				// rearm drops any sweep, single or continuous
				`SWC_CMD_REARM: begin
					state_reg <= ST_RESET;
					cont_reg <= 1'b0;
					out_freq <= start_reg;
					sweep_active <= 1'b0;
					status_byte[`SWC_STB_SWEEP] <= 1'b0;
				end
				// continuous sweep toggles run and stop
				`SWC_CMD_CONT: begin
					// a running sweep stops and does not restart
					if (state_reg == ST_SWEEP) begin
						state_reg <= ST_IDLE;
						sweep_active <= 1'b0;
						status_byte[`SWC_STB_SWEEP] <= 1'b0;
						status_byte[`SWC_STB_STOP] <= 1'b1;
					end else begin
						// repeat from the start frequency
						state_reg <= ST_SWEEP;
						cont_reg <= 1'b1;
						out_freq <= start_reg;
						sweep_active <= 1'b1;
						status_byte[`SWC_STB_SWEEP] <= 1'b1;
						status_byte[`SWC_STB_START] <= 1'b1;
					end
				end
				// single sweep steps through arm, run, stop
				`SWC_CMD_SINGLE, `SWC_CMD_TRIGGER: begin
					// trigger relies on host setup
					if (cmd == `SWC_CMD_TRIGGER && !enhance_reg) begin
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end else begin
						case (state_reg)
						// first press only arms
						ST_IDLE: begin
							state_reg <= ST_RESET;
							out_freq <= start_reg;
						end
						// armed: run exactly one sweep
						ST_RESET: begin
							state_reg <= ST_SWEEP;
							cont_reg <= 1'b0;
							sweep_active <= 1'b1;
							status_byte[`SWC_STB_SWEEP] <= 1'b1;
							status_byte[`SWC_STB_START] <= 1'b1;
						end
						// running: stop and stay stopped
						ST_SWEEP: begin
							state_reg <= ST_IDLE;
							sweep_active <= 1'b0;
							status_byte[`SWC_STB_SWEEP] <= 1'b0;
							status_byte[`SWC_STB_STOP] <= 1'b1;
						end
						// not one-hot: fall back to idle
						default: begin
							state_reg <= ST_IDLE;
						end
						endcase
					end
				end
				// sweep shape select
				`SWC_CMD_SHAPE: begin
					if (arg_reg >= 32'h1 && arg_reg <= 32'h3) begin
						shape_reg <= arg_reg[1:0];
						sweep_shape <= arg_reg[1:0];
					end else begin
						// codes outside 1 to 3 are refused
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// stop frequency, range checked
				`SWC_CMD_END_FREQ: begin
					if (arg_reg <= `SWC_MAX_FREQ) begin
						stop_reg <= arg_reg;
					end else begin
						// old stop kept
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// start frequency, same range as stop
				`SWC_CMD_BEGIN_FREQ: begin
					if (arg_reg <= `SWC_MAX_FREQ) begin
						start_reg <= arg_reg;
					end else begin
						// old start kept
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// sweep time in ms
				`SWC_CMD_DURATION: begin
					// no argument since the last command: report
					if (arg_empty_reg) begin
						time_report <= 1'b1;
					end else if (arg_reg <= `SWC_MAX_TIME) begin
						time_reg <= arg_reg;
					end else begin
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// query only pulses the report strobe
				`SWC_CMD_DUR_QUERY: begin
					time_report <= 1'b1;
				end
				// fixed frequency overrides any sweep
				`SWC_CMD_FREQ_SET: begin
					out_freq <= arg_reg;
					// an armed sweep is dropped as well
					if (state_reg != ST_IDLE) begin
						state_reg <= ST_IDLE;
						sweep_active <= 1'b0;
						status_byte[`SWC_STB_SWEEP] <= 1'b0;
						status_byte[`SWC_STB_STOP] <= 1'b1;
					end
				end
				// store location pointer; the copy is below
				`SWC_CMD_STORE: begin
					if (arg_reg < LOCS) begin
						store_ptr_reg <= arg_reg[3:0];
					end else begin
						status_byte[`SWC_STB_ERR] <= 1'b1;
					end
				end
				// transfer mode survives preset
				`SWC_CMD_XFER_MODE: begin
					xfer_mode_reg <= arg_reg[1:0];
				end
				// enhancements gate the trigger start
				`SWC_CMD_ENHANCE: begin
					enhance_reg <= arg_reg[0];
				end
				// unknown command code
				default: begin
					status_byte[`SWC_STB_ERR] <= 1'b1;
				end
				endcase
			end
		end
	end

	// setup store; memory is not reset, so preset cannot touch it
	always @(posedge clk_sys) begin
		if (!rst && cmd_wr && cmd == `SWC_CMD_STORE && arg_reg < LOCS) begin
			store_mem[arg_reg[3:0]] <= {route_reg, shape_reg, start_reg,
				stop_reg, time_reg};
		end
	end

	// read data, one cycle after the strobe
	always @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
			// argument and state words
			`SWC_OFF_ARG_LO: reg_rdata <= arg_reg;
			`SWC_OFF_STATE: reg_rdata <= {24'h000000, cont_reg,
				enhance_reg, xfer_mode_reg, 1'b0, state_reg};
			// sweep settings
			`SWC_OFF_START: reg_rdata <= start_reg;
			`SWC_OFF_STOP: reg_rdata <= stop_reg;
			`SWC_OFF_TIME: reg_rdata <= time_reg;
			// live output and configuration
			`SWC_OFF_FREQ: reg_rdata <= out_freq;
			`SWC_OFF_CFG: reg_rdata <= {27'h0000000, remote_locked,
				shape_reg, route_reg};
			// event bits are cleared by the main process
			`SWC_OFF_STATUS: reg_rdata <= {24'h000000, status_byte};
			// only the time field of a stored setup is visible
			`SWC_OFF_STORE: reg_rdata <= store_mem[store_ptr_reg][31:0];
			default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			// read data rest at zero between reads
			reg_rdata <= 32'h00000000;
		end
	end

endmodule
`default_nettype wire

// ===== bench/swc_sweep_ctrl_asserts.sv
// assertions for the sweep and output command controller
`timescale 1ns/100ps
`default_nettype none
`include "swc_defs.vh"
module swc_sweep_ctrl_asserts (
	// clock, reset and register port
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// sweep and output hardware
	input wire logic [31:0] out_freq,
	input wire logic rear_sel,
	input wire logic [1:0] sweep_shape,
	input wire logic sweep_active,
	input wire logic remote_locked,
	input wire logic [7:0] status_byte,
	input wire logic time_report
);
	logic [31:0] arg_reg;
	wire logic cw = reg_wr && reg_addr == `SWC_OFF_CMD;
	wire logic [7:0] cm = reg_wdata[7:0];
	// shadow of the argument word, never written with a command
	always_ff @(posedge clk_sys) begin
		if (reg_wr && reg_addr == `SWC_OFF_ARG_LO)
			arg_reg <= reg_wdata;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// report strobe is exactly one cycle wide
	sequence pulse_s;
		time_report ##1 !time_report;
	endsequence
	route_sel_a: assert property (
		cw && cm == `SWC_CMD_ROUTE && (arg_reg == 32'h1 || arg_reg == 32'h2)
		|=> rear_sel == (arg_reg == 32'h2)) else $error("route wrong");
	lockout_set_a: assert property (
		cw && cm == `SWC_CMD_LOCKOUT |=> remote_locked)
		else $error("lockout missing");
	preset_vals_a: assert property (
		cw && cm == `SWC_CMD_PRESET |=> out_freq == `SWC_RST_FREQ
		&& !rear_sel && sweep_shape == 2'h1) else $error("preset values");
	preset_stb_a: assert property (
		cw && cm == `SWC_CMD_PRESET |=> (status_byte & 8'h4F) == 8'h00)
		else $error("preset status");
	shape_sel_a: assert property (
		cw && cm == `SWC_CMD_SHAPE && arg_reg != 32'h0 && arg_reg < 32'h4
		|=> sweep_shape == arg_reg[1:0]) else $error("shape wrong");
	freq_stop_a: assert property (
		cw && cm == `SWC_CMD_FREQ_SET && sweep_active |=> !sweep_active)
		else $error("freq set kept sweep");
	single_stop_a: assert property (
		cw && cm == `SWC_CMD_SINGLE && sweep_active |=> !sweep_active)
		else $error("single kept sweep");
	cont_stop_a: assert property (
		cw && cm == `SWC_CMD_CONT && sweep_active |=> !sweep_active)
		else $error("continuous kept sweep");
	report_a: assert property (
		cw && cm == `SWC_CMD_DUR_QUERY |=> pulse_s)
		else $error("no time report");
	idle_hold_a: assert property (
		!sweep_active && !reg_wr |=> $stable(out_freq))
		else $error("idle freq moved");
endmodule
bind swc_sweep_ctrl swc_sweep_ctrl_asserts u_chk (.clk_sys(clk_sys),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.out_freq(out_freq), .rear_sel(rear_sel), .sweep_shape(sweep_shape),
	.sweep_active(sweep_active), .remote_locked(remote_locked),
	.status_byte(status_byte), .time_report(time_report));
`default_nettype wire

// ===== bench/swc_ctl_model.sv
// remote controller model on the command register port
`timescale 1ns/100ps
`default_nettype none
`include "swc_defs.vh"
module swc_ctl_model (
	// clock and read data
	input wire logic clk_sys,
	input wire logic [31:0] reg_rdata,
	// requests
	output logic [3:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// bus idle from time zero
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one write; returns once the taken edge has settled
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	// argument word always goes before its command code
	task automatic cmd(input logic [7:0] c, input logic [31:0] arg);
		wr(`SWC_OFF_ARG_LO, arg);
		wr(`SWC_OFF_CMD, {24'h0, c});
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// reset code goes bare, so transfer mode 2 never ends it early
	task automatic preset();
		wr(`SWC_OFF_CMD, {24'h0, `SWC_CMD_PRESET});
	endtask
	// trigger start needs enhancements on and a rearmed sweep first
	task automatic trig();
		cmd(`SWC_CMD_ENHANCE, 32'h1);
		wr(`SWC_OFF_CMD, {24'h0, `SWC_CMD_REARM});
		wr(`SWC_OFF_CMD, {24'h0, `SWC_CMD_TRIGGER});
	endtask
endmodule
`default_nettype wire

// ===== bench/swc_sweep_ctrl_tb_top.sv
// self-checking bench for the sweep and output command controller
`timescale 1ns/100ps
`default_nettype none
`include "swc_defs.vh"
module swc_sweep_ctrl_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, out_freq, d;
	logic reg_wr, reg_rd, rear_sel, sweep_active, remote_locked, time_report;
	logic [1:0] sweep_shape;
	logic [7:0] status_byte;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	// short ms tick keeps each sweep step at ten cycles
	swc_sweep_ctrl #(.MS_CYCLES(10)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq(out_freq),
		.rear_sel(rear_sel), .sweep_shape(sweep_shape),
		.sweep_active(sweep_active), .remote_locked(remote_locked),
		.status_byte(status_byte), .time_report(time_report));
	swc_ctl_model u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));
	// 100 MHz clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic c0(input logic [7:0] c);
		u_host.wr(`SWC_OFF_CMD, {24'h0, c});
	endtask
	// bounded wait: a single sweep here is about sixty cycles
	task automatic wait_idle();
		for (int i = 0; i < 200 && sweep_active; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic t_reset();
		chk("freq", `SWC_RST_FREQ, out_freq);
		chk("rear", 32'h0, rear_sel);
		chk("shape", 32'h1, sweep_shape);
		u_host.rd(`SWC_OFF_START, d);
		chk("start", `SWC_RST_START, d);
		u_host.rd(`SWC_OFF_STOP, d);
		chk("stop", `SWC_RST_STOP, d);
		u_host.rd(`SWC_OFF_TIME, d);
		chk("time", `SWC_RST_TIME, d);
		$display("reset test done");
	endtask
	task automatic t_modes();
		for (int i = 1; i < 4; i++) begin
			u_host.cmd(`SWC_CMD_SHAPE, i);
			chk("shape", i, sweep_shape);
		end
		u_host.cmd(`SWC_CMD_ROUTE, 32'h2);
		chk("rear", 32'h1, rear_sel);
		u_host.cmd(`SWC_CMD_ROUTE, 32'h1);
		chk("front", 32'h0, rear_sel);
		c0(`SWC_CMD_LOCKOUT);
		chk("lock", 32'h1, remote_locked);
		$display("mode test done");
	endtask
	task automatic t_sweep();
		u_host.cmd(`SWC_CMD_BEGIN_FREQ, 32'h3E8);
		u_host.cmd(`SWC_CMD_END_FREQ, 32'h5DC);
		c0(`SWC_CMD_SINGLE);
		u_host.rd(`SWC_OFF_STATE, d);
		chk("armed", 32'h2, {sweep_active, d[2:0]});
		chk("at start", 32'h3E8, out_freq);
		c0(`SWC_CMD_SINGLE);
		chk("running", 32'h1, sweep_active);
		wait_idle();
		u_host.rd(`SWC_OFF_STATE, d);
		chk("end state", 32'h1, {sweep_active, d[2:0]});
		chk("end freq", 32'h5DC, out_freq);
		c0(`SWC_CMD_REARM);
		u_host.rd(`SWC_OFF_STATE, d);
		chk("rearm", 32'h2, d[2:0]);
		chk("rearm freq", 32'h3E8, out_freq);
		c0(`SWC_CMD_SINGLE);
		c0(`SWC_CMD_SINGLE);
		chk("single stop", 32'h0, sweep_active);
		c0(`SWC_CMD_CONT);
		repeat (80) @(posedge clk_sys);
		#1;
		chk("cont run", 32'h1, sweep_active);
		c0(`SWC_CMD_CONT);
		chk("cont stop", 32'h0, sweep_active);
		c0(`SWC_CMD_CONT);
		u_host.cmd(`SWC_CMD_FREQ_SET, 32'h7D0);
		chk("fset stop", 32'h0, sweep_active);
		chk("fset freq", 32'h7D0, out_freq);
		c0(`SWC_CMD_TRIGGER);
		chk("trig refused", 32'h1, {sweep_active, status_byte[0]});
		u_host.trig();
		chk("trigger", 32'h1, sweep_active);
		c0(`SWC_CMD_SINGLE);
		$display("sweep test done");
	endtask
	task automatic t_preset();
		u_host.cmd(`SWC_CMD_XFER_MODE, 32'h2);
		u_host.cmd(`SWC_CMD_ROUTE, 32'h2);
		u_host.cmd(`SWC_CMD_SHAPE, 32'h3);
		c0(8'hFF);
		chk("err", 32'h1, status_byte[0]);
		u_host.preset();
		chk("pre out", 32'h0, {rear_sel, sweep_shape != 2'h1});
		chk("pre stb", 32'h0, status_byte & 8'h4F);
		chk("pre freq", `SWC_RST_FREQ, out_freq);
		u_host.rd(`SWC_OFF_STATE, d);
		chk("xfer kept", 32'h6, d[6:4]);
		u_host.rd(`SWC_OFF_START, d);
		chk("pre start", `SWC_RST_START, d);
		$display("preset test done");
	endtask
	task automatic t_limits();
		u_host.cmd(`SWC_CMD_DURATION, `SWC_MAX_TIME);
		u_host.cmd(`SWC_CMD_DURATION, `SWC_MAX_TIME + 32'h1);
		u_host.rd(`SWC_OFF_TIME, d);
		chk("time max", `SWC_MAX_TIME, d);
		u_host.cmd(`SWC_CMD_END_FREQ, `SWC_MAX_FREQ);
		u_host.cmd(`SWC_CMD_END_FREQ, `SWC_MAX_FREQ + 32'h1);
		u_host.rd(`SWC_OFF_STOP, d);
		chk("stop max", `SWC_MAX_FREQ, d);
		u_host.rd(`SWC_OFF_STATUS, d);
		chk("refused", 32'h1, d[0]);
		chk("err read clr", 32'h0, status_byte[0]);
		c0(`SWC_CMD_DUR_QUERY);
		chk("query", 32'h1, time_report);
		c0(`SWC_CMD_DURATION);
		chk("empty set", 32'h1, time_report);
		u_host.cmd(`SWC_CMD_DURATION, 32'h1F4);
		u_host.cmd(`SWC_CMD_STORE, 32'h9);
		u_host.rd(`SWC_OFF_STORE, d);
		chk("store", 32'h1F4, d);
		u_host.preset();
		u_host.rd(`SWC_OFF_STORE, d);
		chk("store kept", 32'h1F4, d);
		$display("limit test done");
	endtask
	// hang guard, far above the three hundred or so cycles needed
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		t_reset();
		t_modes();
		t_sweep();
		t_preset();
		t_limits();
		summarize();
	end
endmodule
`default_nettype wire
